// File: hw/mrau_top.sv
// Memory region attribute unit: region attribute registers, bus control valid bit,
// two logical templates, boot-time table loading and per-access attribute lookup.
// Assumes the core presents each aligned piece of a split request as its own access,
// and holds ACC_ACTIVE_IN high while an external bus access is in progress.
`timescale 1ns/1ps
`default_nettype none
module mrau_top (
    input  wire logic                            CORE_CLK_IN,
    input  wire logic                            RST_IN,
    // Core register port.
    input  wire logic                            REG_WR_IN,
    input  wire logic                            REG_RD_IN,
    input  wire logic [mrau_pkg::REG_SEL_W-1:0]  REG_SEL_IN,
    input  wire logic [31:0]                     REG_WDATA_IN,
    output logic                                 REG_WR_READY_OUT,
    output logic                                 REG_RD_VALID_OUT,
    output logic [31:0]                          REG_RDATA_OUT,
    // Control table fetch from the boot record.
    output logic                                 BOOT_REQ_OUT,
    output logic [mrau_pkg::BOOT_IDX_W-1:0]      BOOT_IDX_OUT,
    input  wire logic                            BOOT_ACK_IN,
    input  wire logic [31:0]                     BOOT_DATA_IN,
    output logic                                 BOOT_DONE_OUT,
    // Access lookup.
    input  wire logic                            ACC_REQ_IN,
    input  wire logic [31:0]                     ACC_ADDR_IN,
    input  wire mrau_pkg::mrau_kind_type         ACC_KIND_IN,
    input  wire logic                            ACC_ACTIVE_IN,
    output logic                                 ACC_VALID_OUT,
    output logic [2:0]                           ACC_WIDTH_OUT,
    output logic [mrau_pkg::NUM_TEMPLATES-1:0]   ACC_TEMPLATE_OUT,
    output logic                                 TABLE_VALID_OUT
);
    import mrau_pkg::*;

    logic [1:0]               region_width_field_q [NUM_REGIONS];
    logic                     table_valid_q;
    logic [19:0]              template_base_field_q [NUM_TEMPLATES];
    logic [19:0]              template_mask_field_q [NUM_TEMPLATES];
    logic                     template_enable_bit_q [NUM_TEMPLATES];
    logic                     pend_q;
    logic                     wr_ready_q;
    logic [2:0]               pend_region_q;
    logic [1:0]               pend_width_q;
    mrau_boot_type            boot_state_q;
    logic [BOOT_IDX_W-1:0]    boot_idx_q;
    logic                     boot_req_q;
    logic                     reg_rd_valid_q;
    logic [31:0]              reg_rdata_q;
    logic                     acc_valid_q;
    logic [2:0]               acc_width_q;
    logic [NUM_TEMPLATES-1:0] acc_template_q;
    logic                     region_wr;
    logic                     apply_now;
    logic [31:0]              rd_word;

    // Region number from the upper three address bits.
    function automatic logic [2:0] region_of(input logic [31:0] addr);
        return addr[REGION_HI:REGION_LO];
    endfunction : region_of

    // Masked compare of the upper twenty address bits; a disabled template never hits.
    function automatic logic template_hit(input logic [31:0] addr, input logic [19:0] base,
                                          input logic [19:0] mask, input logic en);
        return en && (((addr[TMPL_FIELD_HI:TMPL_FIELD_LO] ^ base) & mask) == 20'h0_0000);
    endfunction : template_hit

    // Width code for an external access given its region's two-bit field.
    function automatic logic [2:0] ext_code(input logic [1:0] bw);
        logic [2:0] code;
        code = WC_EXT_RESERVED;
        unique case (bw)
            BW_8:        code = WC_EXT_8;
            BW_16:       code = WC_EXT_16;
            BW_32:       code = WC_EXT_32;
            BW_RESERVED: code = WC_EXT_RESERVED;
        endcase
        return code;
    endfunction : ext_code

    // A region register write from the core; boot loading does not go through here.
    assign region_wr = REG_WR_IN && !pend_q && (REG_SEL_IN <= IDX_REGION_TOP);
    // The held write lands only once no bus access is in flight.
    assign apply_now = pend_q && !ACC_ACTIVE_IN;

    // Boot loader: eight region entries first, bus control last.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            boot_state_q <= BOOT_REGIONS;
            boot_idx_q   <= '0;
            boot_req_q   <= 1'b1;
        end else begin
            unique case (boot_state_q)
                BOOT_REGIONS: begin
                    if (BOOT_ACK_IN) begin
                        boot_idx_q <= boot_idx_q + 4'h1;
                        if (boot_idx_q == IDX_REGION_TOP) begin
                            boot_state_q <= BOOT_BUS_CTL;
                        end
                    end
                end
                BOOT_BUS_CTL: begin
                    if (BOOT_ACK_IN) begin
                        boot_state_q <= BOOT_DONE;
                        boot_req_q   <= 1'b0;
                    end
                end
                BOOT_DONE: begin
                    boot_req_q <= 1'b0;
                end
            endcase
        end
    end

    // Region width fields: boot load, then core writes held across an active access.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            for (int i = 0; i < NUM_REGIONS; i++) begin
                region_width_field_q[i] <= REGION_ATTR_RST[WIDTH_FIELD_HI:WIDTH_FIELD_LO];
            end
        end else if ((boot_state_q == BOOT_REGIONS) && BOOT_ACK_IN) begin
            region_width_field_q[boot_idx_q[2:0]] <= BOOT_DATA_IN[WIDTH_FIELD_HI:WIDTH_FIELD_LO];
        end else if (apply_now) begin
            region_width_field_q[pend_region_q] <= pend_width_q;
        end else if (region_wr && !ACC_ACTIVE_IN) begin
            region_width_field_q[REG_SEL_IN[2:0]] <= REG_WDATA_IN[WIDTH_FIELD_HI:WIDTH_FIELD_LO];
        end
    end

    // Hold slot for a region write that arrived during an access; it blocks a second write.
    // The ready flag is kept as its own flop so the port is not driven through an inverter.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            pend_q        <= 1'b0;
            pend_region_q <= 3'h0;
            pend_width_q  <= 2'h0;
            wr_ready_q    <= 1'b1;
        end else if (apply_now) begin
            pend_q     <= 1'b0;
            wr_ready_q <= 1'b1;
        end else if (region_wr && ACC_ACTIVE_IN) begin
            pend_q        <= 1'b1;
            wr_ready_q    <= 1'b0;
            pend_region_q <= REG_SEL_IN[2:0];
            pend_width_q  <= REG_WDATA_IN[WIDTH_FIELD_HI:WIDTH_FIELD_LO];
        end
    end

    // Table-valid bit: cleared by reset, loaded last from the table, writable afterwards.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            table_valid_q <= BUS_CTL_RST[TABLE_VALID_BIT];
        end else if ((boot_state_q == BOOT_BUS_CTL) && BOOT_ACK_IN) begin
            table_valid_q <= BOOT_DATA_IN[TABLE_VALID_BIT];
        end else if (REG_WR_IN && (REG_SEL_IN == IDX_BUS_CTL)) begin
            table_valid_q <= REG_WDATA_IN[TABLE_VALID_BIT];
        end
    end

    // Template enables reset to off; base and mask fields are not reset and may be unknown.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            for (int t = 0; t < NUM_TEMPLATES; t++) begin
                template_enable_bit_q[t] <= TEMPLATE_EN_RST;
            end
        end else if (REG_WR_IN && (REG_SEL_IN == IDX_TMASK0)) begin
            template_enable_bit_q[0] <= REG_WDATA_IN[TEMPLATE_EN_BIT];
        end else if (REG_WR_IN && (REG_SEL_IN == IDX_TMASK1)) begin
            template_enable_bit_q[1] <= REG_WDATA_IN[TEMPLATE_EN_BIT];
        end
    end

    // Template base and mask fields.
    always_ff @(posedge CORE_CLK_IN) begin
        if (REG_WR_IN && !RST_IN) begin
            unique case (REG_SEL_IN)
                IDX_TBASE0: template_base_field_q[0] <= REG_WDATA_IN[TMPL_FIELD_HI:TMPL_FIELD_LO];
                IDX_TBASE1: template_base_field_q[1] <= REG_WDATA_IN[TMPL_FIELD_HI:TMPL_FIELD_LO];
                IDX_TMASK0: template_mask_field_q[0] <= REG_WDATA_IN[TMPL_FIELD_HI:TMPL_FIELD_LO];
                IDX_TMASK1: template_mask_field_q[1] <= REG_WDATA_IN[TMPL_FIELD_HI:TMPL_FIELD_LO];
                default: ;
            endcase
        end
    end

    // Read mux; unimplemented bits and unused indices read as zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        if (REG_SEL_IN <= IDX_REGION_TOP) begin
            rd_word[WIDTH_FIELD_HI:WIDTH_FIELD_LO] = region_width_field_q[REG_SEL_IN[2:0]];
        end else if (REG_SEL_IN == IDX_BUS_CTL) begin
            rd_word[TABLE_VALID_BIT] = table_valid_q;
        end else if (REG_SEL_IN == IDX_TBASE0) begin
            rd_word[TMPL_FIELD_HI:TMPL_FIELD_LO] = template_base_field_q[0];
        end else if (REG_SEL_IN == IDX_TBASE1) begin
            rd_word[TMPL_FIELD_HI:TMPL_FIELD_LO] = template_base_field_q[1];
        end else if (REG_SEL_IN == IDX_TMASK0) begin
            rd_word[TMPL_FIELD_HI:TMPL_FIELD_LO] = template_mask_field_q[0];
            rd_word[TEMPLATE_EN_BIT]              = template_enable_bit_q[0];
        end else if (REG_SEL_IN == IDX_TMASK1) begin
            rd_word[TMPL_FIELD_HI:TMPL_FIELD_LO] = template_mask_field_q[1];
            rd_word[TEMPLATE_EN_BIT]              = template_enable_bit_q[1];
        end
    end

    // Registered read answer, one cycle after the strobe.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            reg_rd_valid_q <= 1'b0;
            reg_rdata_q    <= 32'h0000_0000;
        end else begin
            reg_rd_valid_q <= REG_RD_IN;
            if (REG_RD_IN) begin
                reg_rdata_q <= rd_word;
            end
        end
    end

    // Access lookup: with the table valid, each presented piece is decoded by its own address, so a split
    // request picks up both regions' widths without extra state.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            acc_valid_q    <= 1'b0;
            acc_width_q    <= WC_EXT_8;
            acc_template_q <= '0;
        end else begin
            acc_valid_q <= ACC_REQ_IN;
            if (ACC_REQ_IN) begin
                unique case (ACC_KIND_IN)
                    KIND_EXTERNAL: begin
                        if (table_valid_q) begin
                            acc_width_q <= ext_code(region_width_field_q[region_of(ACC_ADDR_IN)]);
                        end else begin
                            acc_width_q <= ext_code(region_width_field_q[IDX_REGION_TOP[2:0]]);
                        end
                    end
                    KIND_INT_RAM:   acc_width_q <= WC_INTERNAL_32;
                    KIND_MMR:       acc_width_q <= WC_INTERNAL_32;
                    KIND_REG_CACHE: acc_width_q <= WC_REG_BUS_128;
                endcase
                // Templates do not apply to memory-mapped register accesses.
                for (int t = 0; t < NUM_TEMPLATES; t++) begin
                    acc_template_q[t] <= (ACC_KIND_IN != KIND_MMR) &&
                        template_hit(ACC_ADDR_IN, template_base_field_q[t],
                                     template_mask_field_q[t], template_enable_bit_q[t]);
                end
            end
        end
    end

    assign REG_WR_READY_OUT = wr_ready_q;
    assign REG_RD_VALID_OUT = reg_rd_valid_q;
    assign REG_RDATA_OUT    = reg_rdata_q;
    assign BOOT_REQ_OUT     = boot_req_q;
    assign BOOT_IDX_OUT     = boot_idx_q;
    assign BOOT_DONE_OUT    = boot_state_q[2];
    assign ACC_VALID_OUT    = acc_valid_q;
    assign ACC_WIDTH_OUT    = acc_width_q;
    assign ACC_TEMPLATE_OUT = acc_template_q;
    assign TABLE_VALID_OUT  = table_valid_q;
endmodule : mrau_top
`default_nettype wire

// File: hw/mrau_pkg.sv
// Constants for the memory region attribute unit: register indices, field positions,
// reset values, access kinds and width codes.
// Assumes a single core clock and a core that reaches these registers by index.
// Summary of operation
// - Each region takes its external bus width from a two-bit field; 11 is reserved.
// - At initialization all eight region attribute registers load from the boot record table.
// - Hardware reset clears the table-valid bit, marking region attributes invalid.
// - While invalid, the top region's attributes apply to every region.
// - Reset clears the top region register, so all regions start at 8-bit width.
// - The bus control register loads from the table after all region registers.
// - After loading, valid bit set selects per-region attributes, clear keeps top region.
// - Internal memory and registers use 32-bit buses; register cache uses 128 bits.
// - A request spanning two regions uses each region's attributes for its pieces.
// - A region register write during a bus access takes effect after that access.
// - Template mask register holds a 20-bit mask in bits 31 to 12.
// - Region comes from the upper three address bits: eight 512 Mbyte regions.
// - Template matches when all masked upper address bits equal the base bits.
// - A template with its enable clear never affects any access.
// - Reset clears every template enable bit; other mask bits stay undefined.
package mrau_pkg;
    localparam int          NUM_REGIONS      = 8;
    localparam int          NUM_TEMPLATES    = 2;
    localparam int          REG_SEL_W        = 4;
    localparam int          BOOT_IDX_W       = 4;
    // Register indices on the core register port.
    localparam logic [3:0]  IDX_REGION_FIRST = 4'h0;
    localparam logic [3:0]  IDX_REGION_TOP   = 4'h7;
    localparam logic [3:0]  IDX_BUS_CTL      = 4'h8;
    localparam logic [3:0]  IDX_TBASE0       = 4'h9;
    localparam logic [3:0]  IDX_TBASE1       = 4'ha;
    localparam logic [3:0]  IDX_TMASK0       = 4'hb;
    localparam logic [3:0]  IDX_TMASK1       = 4'hc;
    // Field positions.
    localparam int          WIDTH_FIELD_LO   = 24;
    localparam int          WIDTH_FIELD_HI   = 25;
    localparam int          TABLE_VALID_BIT  = 0;
    localparam int          TEMPLATE_EN_BIT  = 0;
    localparam int          TMPL_FIELD_LO    = 12;
    localparam int          TMPL_FIELD_HI    = 31;
    localparam int          REGION_LO        = 29;
    localparam int          REGION_HI        = 31;
    // Masks of implemented bits and reset values.
    localparam logic [31:0] REGION_ATTR_MASK = 32'h0300_0000;
    localparam logic [31:0] BUS_CTL_MASK     = 32'h0000_0001;
    localparam logic [31:0] TBASE_MASK       = 32'hffff_f000;
    localparam logic [31:0] TMASK_MASK       = 32'hffff_f001;
    localparam logic [31:0] REGION_ATTR_RST  = 32'h0000_0000;
    localparam logic [31:0] BUS_CTL_RST      = 32'h0000_0000;
    localparam logic        TEMPLATE_EN_RST  = 1'b0;
    // Bus width field encodings.
    localparam logic [1:0]  BW_8             = 2'h0;
    localparam logic [1:0]  BW_16            = 2'h1;
    localparam logic [1:0]  BW_32            = 2'h2;
    localparam logic [1:0]  BW_RESERVED      = 2'h3;
    // Access kinds presented by the core.
    typedef enum logic [1:0] {
        KIND_EXTERNAL = 2'h0,
        KIND_INT_RAM  = 2'h1,
        KIND_MMR      = 2'h2,
        KIND_REG_CACHE = 2'h3
    } mrau_kind_type;
    // Width codes driven on the access answer.
    localparam logic [2:0]  WC_EXT_8         = 3'h0;
    localparam logic [2:0]  WC_EXT_16        = 3'h1;
    localparam logic [2:0]  WC_EXT_32        = 3'h2;
    localparam logic [2:0]  WC_EXT_RESERVED  = 3'h3;
    localparam logic [2:0]  WC_INTERNAL_32   = 3'h4;
    localparam logic [2:0]  WC_REG_BUS_128   = 3'h5;
    // Boot loader states.
    typedef enum logic [2:0] {
        BOOT_REGIONS = 3'b001,
        BOOT_BUS_CTL = 3'b010,
        BOOT_DONE    = 3'b100
    } mrau_boot_type;
endpackage : mrau_pkg

// File: verification/mrau_properties.sv
// Checker for the memory region attribute unit, watching only the top module ports.
// Assumes mrau_pkg is compiled first; the bind at the foot attaches it to mrau_top.
`timescale 1ns/1ps
`default_nettype none
module mrau_properties (
    input wire logic                            CORE_CLK_IN,
    input wire logic                            RST_IN,
    input wire logic                            REG_WR_IN,
    input wire logic                            REG_RD_IN,
    input wire logic [mrau_pkg::REG_SEL_W-1:0]  REG_SEL_IN,
    input wire logic [31:0]                     REG_WDATA_IN,
    input wire logic                            REG_WR_READY_OUT,
    input wire logic                            REG_RD_VALID_OUT,
    input wire logic [31:0]                     REG_RDATA_OUT,
    input wire logic                            BOOT_REQ_OUT,
    input wire logic [mrau_pkg::BOOT_IDX_W-1:0] BOOT_IDX_OUT,
    input wire logic                            BOOT_ACK_IN,
    input wire logic [31:0]                     BOOT_DATA_IN,
    input wire logic                            BOOT_DONE_OUT,
    input wire logic                            ACC_REQ_IN,
    input wire logic [31:0]                     ACC_ADDR_IN,
    input wire mrau_pkg::mrau_kind_type         ACC_KIND_IN,
    input wire logic                            ACC_ACTIVE_IN,
    input wire logic                            ACC_VALID_OUT,
    input wire logic [2:0]                      ACC_WIDTH_OUT,
    input wire logic [mrau_pkg::NUM_TEMPLATES-1:0] ACC_TEMPLATE_OUT,
    input wire logic                            TABLE_VALID_OUT
);
    import mrau_pkg::*;
    // Everything here lives in the core clock domain, so one clocking and one reset serve all.
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    a_reset_marks_invalid: assert property ($fell(RST_IN) |-> !TABLE_VALID_OUT && BOOT_REQ_OUT && BOOT_IDX_OUT == 4'h0)
        else $error("table valid or boot request wrong after reset");
    a_reset_tmpl_off: assert property ($fell(RST_IN) |-> ACC_TEMPLATE_OUT == 2'h0 && !ACC_VALID_OUT)
        else $error("template hit seen straight after reset");
    a_boot_index_step: assert property (BOOT_REQ_OUT && BOOT_ACK_IN && BOOT_IDX_OUT < 4'h8 |=>
        BOOT_REQ_OUT && BOOT_IDX_OUT == $past(BOOT_IDX_OUT) + 4'h1) else $error("boot index did not advance");
    a_bus_ctl_last: assert property ($rose(BOOT_DONE_OUT) |-> $past(BOOT_IDX_OUT) == 4'h8 && $past(BOOT_ACK_IN))
        else $error("boot finished before the bus control entry");
    a_boot_valid_load: assert property (BOOT_REQ_OUT && BOOT_ACK_IN && BOOT_IDX_OUT == 4'h8 |=>
        BOOT_DONE_OUT && !BOOT_REQ_OUT && TABLE_VALID_OUT == $past(BOOT_DATA_IN[0])) else $error("valid bit not loaded");
    a_internal_width: assert property (ACC_REQ_IN && (ACC_KIND_IN == KIND_INT_RAM || ACC_KIND_IN == KIND_MMR) |=>
        ACC_VALID_OUT && ACC_WIDTH_OUT == WC_INTERNAL_32) else $error("internal access width wrong");
    a_reg_bus_width: assert property (ACC_REQ_IN && ACC_KIND_IN == KIND_REG_CACHE |=>
        ACC_VALID_OUT && ACC_WIDTH_OUT == WC_REG_BUS_128) else $error("register cache width wrong");
    a_write_held_busy: assert property (REG_WR_IN && REG_SEL_IN < 4'h8 && REG_WR_READY_OUT && ACC_ACTIVE_IN |=>
        !REG_WR_READY_OUT) else $error("region write during access not held");
    a_held_release: assert property (!REG_WR_READY_OUT |=> REG_WR_READY_OUT == !$past(ACC_ACTIVE_IN))
        else $error("held region write released at wrong time");
    c_boot_valid: cover property (BOOT_DONE_OUT && TABLE_VALID_OUT);
    c_held_write: cover property (!REG_WR_READY_OUT);
    c_template_hit: cover property (ACC_VALID_OUT && ACC_TEMPLATE_OUT != 2'h0);
endmodule : mrau_properties
bind mrau_top mrau_properties i_props (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_SEL_IN(REG_SEL_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_READY_OUT(REG_WR_READY_OUT),
    .REG_RD_VALID_OUT(REG_RD_VALID_OUT), .REG_RDATA_OUT(REG_RDATA_OUT), .BOOT_REQ_OUT(BOOT_REQ_OUT),
    .BOOT_IDX_OUT(BOOT_IDX_OUT), .BOOT_ACK_IN(BOOT_ACK_IN), .BOOT_DATA_IN(BOOT_DATA_IN), .BOOT_DONE_OUT(BOOT_DONE_OUT),
    .ACC_REQ_IN(ACC_REQ_IN), .ACC_ADDR_IN(ACC_ADDR_IN), .ACC_KIND_IN(ACC_KIND_IN), .ACC_ACTIVE_IN(ACC_ACTIVE_IN),
    .ACC_VALID_OUT(ACC_VALID_OUT), .ACC_WIDTH_OUT(ACC_WIDTH_OUT), .ACC_TEMPLATE_OUT(ACC_TEMPLATE_OUT),
    .TABLE_VALID_OUT(TABLE_VALID_OUT));
`default_nettype wire

// File: verification/mrau_boot_model.sv
// Boot record model: serves control table entries to the unit on request.
// Assumes one core clock; stall_in lets the bench make it answer slowly.
`timescale 1ns/1ps
`default_nettype none
module mrau_boot_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        req_in,
    input  wire logic [3:0]  idx_in,
    input  wire logic        stall_in,
    input  wire logic        ctv_in,
    input  wire logic [15:0] widths_in,
    output logic             ack_out,
    output logic [31:0]      data_out
);
    // Filler bits around the width field check that the unit keeps only its own field.
    // Between acks the data is inverted every cycle, since a stale value must not be trusted.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack_out  <= 1'b0;
            data_out <= 32'h0;
        end else if (req_in && !ack_out && !stall_in) begin
            ack_out  <= 1'b1;
            data_out <= (idx_in < 4'h8) ? {6'h15, widths_in[{idx_in[2:0], 1'b0} +: 2], 24'ha5a5a5}
                                        : {31'h2b3c4d5e, ctv_in};
        end else begin
            ack_out  <= 1'b0;
            data_out <= ~data_out;
        end
    end
endmodule : mrau_boot_model
`default_nettype wire

// File: verification/mrau_tb_top.sv
// Self-checking bench for the memory region attribute unit with a boot record model.
// Assumes the design's package and top module; expectations go through two queues.
`timescale 1ns/1ps
`default_nettype none
module mrau_tb_top;
    import mrau_pkg::*;
    localparam logic [15:0] WTAB = {2'h1, 2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0};
    logic          clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, acc_req = 1'b0, acc_active = 1'b0;
    logic [3:0]    reg_sel = 4'h0, boot_idx;
    logic [31:0]   reg_wdata = 32'h0, acc_addr = 32'h0, rdata, boot_data;
    logic          wr_ready, rd_valid, boot_req, boot_ack, boot_done, acc_valid, table_valid;
    logic          stall = 1'b1, hold = 1'b1, ctv = 1'b0;
    logic [2:0]    acc_width;
    logic [1:0]    acc_tmpl;
    mrau_kind_type acc_kind = KIND_EXTERNAL;
    integer        seed = 32'h319a8788, err_total = 0, comparisons = 0, cyc = 0;
    logic [4:0]    acc_q[$];
    logic [31:0]   rd_q[$];

    mrau_top i_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_SEL_IN(reg_sel),
        .REG_WDATA_IN(reg_wdata), .REG_WR_READY_OUT(wr_ready), .REG_RD_VALID_OUT(rd_valid), .REG_RDATA_OUT(rdata),
        .BOOT_REQ_OUT(boot_req), .BOOT_IDX_OUT(boot_idx), .BOOT_ACK_IN(boot_ack), .BOOT_DATA_IN(boot_data),
        .BOOT_DONE_OUT(boot_done), .ACC_REQ_IN(acc_req), .ACC_ADDR_IN(acc_addr), .ACC_KIND_IN(acc_kind),
        .ACC_ACTIVE_IN(acc_active), .ACC_VALID_OUT(acc_valid), .ACC_WIDTH_OUT(acc_width),
        .ACC_TEMPLATE_OUT(acc_tmpl), .TABLE_VALID_OUT(table_valid));
    mrau_boot_model i_boot (.clk_in(clk), .rst_in(rst), .req_in(boot_req), .idx_in(boot_idx), .stall_in(stall),
        .ctv_in(ctv), .widths_in(WTAB), .ack_out(boot_ack), .data_out(boot_data));

    // Clock, random model stalls and the cycle ceiling that cuts a hang short.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        stall <= hold | (($random(seed) & 1) != 0);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk_acc(input logic [4:0] got, input logic [4:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t lookup got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask : chk_acc

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t word got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask : chk_word

    // Expected lookup result of an external access: width code then template hits.
    function automatic logic [4:0] ext(input int r, input logic [1:0] t);
        return {1'b0, WTAB[2*r +: 2], t};
    endfunction : ext

    task automatic acc(input logic [31:0] a, input mrau_kind_type k, input logic [4:0] e);
        acc_q.push_back(e);
        @(posedge clk);
        acc_req <= 1'b1;
        acc_addr <= a;
        acc_kind <= k;
        @(posedge clk);
        acc_req <= 1'b0;
    endtask : acc

    task automatic rd(input logic [3:0] s, input logic [31:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_sel <= s;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic wr(input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_sel <= s;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // The wait is bounded; a boot that never ends shows up as a failed compare.
    task automatic wait_boot();
        for (int i = 0; i < 400 && boot_done !== 1'b1; i++) @(posedge clk);
        #1 chk_word({31'h0, boot_done}, 32'h1);
    endtask : wait_boot

    // Results are compared against the oldest note as they come out of the registered outputs.
    always @(posedge clk) begin
        if (acc_valid === 1'b1) chk_acc({acc_width, acc_tmpl}, acc_q.size() ? acc_q.pop_front() : 5'bx);
        if (rd_valid === 1'b1) chk_word(rdata, rd_q.size() ? rd_q.pop_front() : 32'bx);
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        acc(32'h4000_0000, KIND_EXTERNAL, 5'h00);
        rd(IDX_BUS_CTL, 32'h0);
        rd(IDX_REGION_TOP, 32'h0);
        hold <= 1'b0;
        wait_boot();
        for (int r = 0; r < 8; r++) acc({r[2:0], 29'($random(seed))}, KIND_EXTERNAL, ext(7, 2'h0));
        for (int k = 1; k < 4; k++) acc(32'he000_0000, mrau_kind_type'(k), (k == 3) ? 5'h14 : 5'h10);
        // A second reset in mid-run, this time with the table marked valid.
        rst <= 1'b1;
        ctv <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wait_boot();
        chk_word({31'h0, table_valid}, 32'h1);
        for (int r = 0; r < 8; r++) begin
            acc({r[2:0], 29'($random(seed))}, KIND_EXTERNAL, ext(r, 2'h0));
            rd(r[3:0], {6'h0, WTAB[2*r +: 2], 24'h0});
        end
        rd(IDX_BUS_CTL, 32'h1);
        acc(32'h1fff_fffe, KIND_EXTERNAL, ext(0, 2'h0));
        acc(32'h2000_0000, KIND_EXTERNAL, ext(1, 2'h0));
        acc_active <= 1'b1;
        wr(4'h2, 32'hfcff_ffff);
        #1 chk_word({31'h0, wr_ready}, 32'h0);
        acc(32'h4000_0000, KIND_EXTERNAL, ext(2, 2'h0));
        acc_active <= 1'b0;
        repeat (2) @(posedge clk);
        acc(32'h5000_0000, KIND_EXTERNAL, 5'h00);
        rd(4'h2, 32'h0);
        wr(IDX_TBASE0, 32'h0010_0abc);
        wr(IDX_TMASK0, 32'hffff_0ff1);
        wr(IDX_TBASE1, 32'h0020_0000);
        wr(IDX_TMASK1, 32'hfff0_0000);
        rd(IDX_TMASK0, 32'hffff_0001);
        acc(32'h0010_5678, KIND_EXTERNAL, ext(0, 2'h1));
        acc(32'h0011_0000, KIND_EXTERNAL, ext(0, 2'h0));
        acc(32'h0025_0000, KIND_EXTERNAL, ext(0, 2'h0));
        acc(32'h0010_0000, KIND_MMR, 5'h10);
        wr(IDX_TMASK1, 32'hfff0_0001);
        acc(32'h0025_0000, KIND_EXTERNAL, ext(0, 2'h2));
        repeat (4) @(posedge clk);
        chk_word(32'(acc_q.size() + rd_q.size()), 32'h0);
        stop_test();
    end
endmodule : mrau_tb_top
`default_nettype wire
